// File: design/rvp_pkg.sv
// Package: register map, field positions, timing and carrier types
package rvp_pkg;

  // Register offsets (command codes)
  localparam logic [7:0] ADDR_STATUS_INFO_ONE = 8'h3a;
  localparam logic [7:0] ADDR_CONTROL_WORD_ONE = 8'h3c;
  localparam logic [7:0] ADDR_CONTROL_WORD_TWO = 8'h3d;
  localparam logic [7:0] ADDR_REV_OUT_VOLTAGE = 8'h49;
  localparam logic [7:0] ADDR_REV_OUT_CUR_LIMIT = 8'h4a;

  // Reset values
  localparam logic [15:0] RST_CONTROL_WORD_ONE = 16'h0000;
  localparam logic [15:0] RST_CONTROL_WORD_TWO = 16'h0000;
  localparam logic [15:0] RST_REV_OUT_VOLTAGE = 16'h0000;
  localparam logic [15:0] RST_REV_OUT_CUR_LIMIT = 16'h0200;
  localparam logic [15:0] REV_VOLT_FIELD_MASK = 16'h7ff8;

  // Control word one fields
  localparam int C1_REV_ENABLE = 11;
  localparam int C1_PWR_MON_ENABLE = 3;
  // Control word two fields
  localparam int C2_REV_DEB_SEL = 13;
  localparam int C2_WOC_DEB_SEL = 11;
  localparam int C2_ASG_FORCE_OFF = 5;
  localparam int C2_CMP_REF_SEL = 4;
  localparam int C2_CMP_DISABLE = 3;
  localparam int C2_CMP_INVERT = 2;
  localparam int C2_WOC_DISABLE = 1;
  localparam int C2_BOV_DISABLE = 0;
  // Status info one fields
  localparam int S1_REF_ON = 15;
  localparam int S1_MODE_HI = 6;
  localparam int S1_MODE_LO = 5;
  localparam logic [1:0] MODE_REVERSE = 2'h3;
  localparam logic [1:0] MODE_OTHER = 2'h0;

  // Timing, figures in ns, counts derived for the reference clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_REV_DEB_LONG_NS = 1300000000;
  localparam int unsigned T_REV_DEB_SHORT_NS = 150000000;
  localparam int unsigned T_REV_UV_NS = 32000000;
  localparam int unsigned T_RECOVER_NS = 100000;
  localparam int unsigned T_ADP_OV_NS = 10000;
  localparam int unsigned T_BAT_OV_NS = 1000000;
  localparam int unsigned T_WOC_WIN_NS = 10000;
  localparam int unsigned T_WOC_ACC_NS = 50000000;
  localparam int unsigned CY_REV_DEB_LONG =
    (T_REV_DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CY_REV_DEB_SHORT =
    (T_REV_DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CY_REV_UV =
    (T_REV_UV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CY_RECOVER =
    (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CY_ADP_OV =
    (T_ADP_OV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CY_BAT_OV =
    (T_BAT_OV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CY_WOC_WIN = T_WOC_WIN_NS / CLK_PERIOD_NS;
  localparam int unsigned CY_WOC_ACC = T_WOC_ACC_NS / CLK_PERIOD_NS;
  localparam logic [2:0] WOC_TRIP_COUNT = 3'h7;

  // Timer slots
  localparam int TM_REV_DEB = 0;
  localparam int TM_REV_UV = 1;
  localparam int TM_REV_OV = 2;
  localparam int TM_ADP_SET = 3;
  localparam int TM_ADP_CLR = 4;
  localparam int TM_BOV_SET = 5;
  localparam int TM_BOV_CLR = 6;
  localparam int TM_OT_CLR = 7;
  localparam int TM_WOC_WIN = 8;
  localparam int TM_WOC_ACC = 9;
  localparam int TM_WOC_DEB = 10;
  localparam int TM_COUNT = 11;

  // Reverse mode states, Gray along off-debounce-run
  typedef enum logic [2:0] {
    RV_OFF = 3'h0,
    RV_DEBOUNCE = 3'h1,
    RV_RUN = 3'h3,
    RV_OV_HOLD = 3'h2
  } rvp_rev_state_t;

  // Register access from the command layer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } rvp_reg_req_t;

  // Comparator results and pin levels from the analog side
  typedef struct packed {
    logic adp_valid;
    logic vbat_above_min;
    logic battery_absent_pin;
    logic single_cell;
    logic reverse_enable_pin;
    logic input_sense_below_ov;
    logic rev_at_target;
    logic rev_uv;
    logic rev_ov;
    logic cmp_above_ref;
    logic adp_ov;
    logic adp_below_low;
    logic bat_ov;
    logic bat_below_half;
    logic sys_ov;
    logic sys_below_hyst;
    logic woc_trip;
    logic ot_high;
    logic ot_below_low;
  } rvp_sense_t;

endpackage

// File: design/rvp_timer.sv
// Qualification timer: counts while run is held, reports reaching limit
`timescale 1ns/10ps
`default_nettype none
module rvp_timer #(
  parameter int W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [W-1:0] i_limit,
  output logic o_done
);

  logic [W-1:0] cnt_q; // Elapsed cycles of the current run

  // Count up while run holds, saturate at limit, restart when run drops
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || !i_run)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q != i_limit)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Level, high while run holds and the limit has been reached
  assign o_done = i_run && (cnt_q == i_limit);

endmodule
`default_nettype wire

// File: design/rvp_ctrl.sv
// Reverse output sequencing, shared-pin comparator and fault supervisor
`timescale 1ns/10ps
`default_nettype none
module rvp_ctrl #(
  parameter int unsigned P_REV_DEB_LONG = rvp_pkg::CY_REV_DEB_LONG,
  parameter int unsigned P_REV_DEB_SHORT = rvp_pkg::CY_REV_DEB_SHORT,
  parameter int unsigned P_REV_UV = rvp_pkg::CY_REV_UV,
  parameter int unsigned P_RECOVER = rvp_pkg::CY_RECOVER,
  parameter int unsigned P_ADP_OV = rvp_pkg::CY_ADP_OV,
  parameter int unsigned P_BAT_OV = rvp_pkg::CY_BAT_OV,
  parameter int unsigned P_WOC_WIN = rvp_pkg::CY_WOC_WIN,
  parameter int unsigned P_WOC_ACC = rvp_pkg::CY_WOC_ACC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire rvp_pkg::rvp_reg_req_t i_reg,
  input wire rvp_pkg::rvp_sense_t i_sense,
  output logic [15:0] o_reg_rdata,
  output logic o_switch_en,
  output logic o_adapter_switch_gate,
  output logic o_battery_switch_gate,
  output logic o_adapter_present_flag,
  output logic o_shared_out_pin,
  output logic o_cmp_ref_high,
  output logic [15:0] o_rev_voltage_target,
  output logic [15:0] o_rev_current_limit
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  rvp_pkg::rvp_sense_t meta_q; // First stage, read by the second only
  rvp_pkg::rvp_sense_t sn; // Settled comparator results

  // Two flops on every analog result; first stage feeds nothing else
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      meta_q <= '0;
      sn <= '0;
    end
    else
    begin
      meta_q <= i_sense;
      sn <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] ctl1_q; // Control word one
  logic [15:0] ctl2_q; // Control word two
  logic [15:0] vout_q; // Reverse output voltage
  logic [15:0] ilim_q; // Reverse output current limit
  logic [15:0] info_d; // Status info one, live
  logic [15:0] rdata_d;
  rvp_pkg::rvp_rev_state_t st_q; // Reverse sequencer state
  rvp_pkg::rvp_rev_state_t st_d;

  // Write decode; unmapped and read-only addresses ignore writes
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      ctl1_q <= rvp_pkg::RST_CONTROL_WORD_ONE;
      ctl2_q <= rvp_pkg::RST_CONTROL_WORD_TWO;
      vout_q <= rvp_pkg::RST_REV_OUT_VOLTAGE;
      ilim_q <= rvp_pkg::RST_REV_OUT_CUR_LIMIT;
    end
    else if (i_reg.wr)
    begin
      case (i_reg.addr)
        rvp_pkg::ADDR_CONTROL_WORD_ONE: ctl1_q <= i_reg.wdata;
        rvp_pkg::ADDR_CONTROL_WORD_TWO: ctl2_q <= i_reg.wdata;
        rvp_pkg::ADDR_REV_OUT_VOLTAGE:
          vout_q <= i_reg.wdata & rvp_pkg::REV_VOLT_FIELD_MASK;
        rvp_pkg::ADDR_REV_OUT_CUR_LIMIT: ilim_q <= i_reg.wdata;
        default: ;
      endcase
    end
  end

  // Internal reference runs with adapter, or battery-only with monitor on
  logic ref_on;
  assign ref_on = sn.adp_valid || ctl1_q[rvp_pkg::C1_PWR_MON_ENABLE];

  // Status info: reference state and operating mode
  always_comb
  begin
    info_d = '0;
    info_d[rvp_pkg::S1_REF_ON] = ref_on;
    info_d[rvp_pkg::S1_MODE_HI:rvp_pkg::S1_MODE_LO] =
      (st_q == rvp_pkg::RV_RUN) ? rvp_pkg::MODE_REVERSE
                                : rvp_pkg::MODE_OTHER;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    case (i_reg.addr)
      rvp_pkg::ADDR_STATUS_INFO_ONE: rdata_d = info_d;
      rvp_pkg::ADDR_CONTROL_WORD_ONE: rdata_d = ctl1_q;
      rvp_pkg::ADDR_CONTROL_WORD_TWO: rdata_d = ctl2_q;
      rvp_pkg::ADDR_REV_OUT_VOLTAGE: rdata_d = vout_q;
      rvp_pkg::ADDR_REV_OUT_CUR_LIMIT: rdata_d = ilim_q;
      default: rdata_d = '0;
    endcase
  end

  // Read data held until the next read strobe
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= '0;
    end
    else if (i_reg.rd)
    begin
      o_reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delay timers
  logic [rvp_pkg::TM_COUNT-1:0] tm_run;
  logic [rvp_pkg::TM_COUNT-1:0] tm_done;
  logic [31:0] tm_lim [rvp_pkg::TM_COUNT];
  logic adp_flt_q, bov_flt_q, sys_flt_q, ot_flt_q, woc_flt_q;
  logic [2:0] woc_cnt_q; // Trips counted in this accumulation window
  logic woc_seen_q; // A trip was already counted in this sample window
  logic woc_tick_q; // Sample window just ended; restarts its timer
  logic rev_en, cmp_en, rev_qual;

  // One timer per delay; all delays are clocked counts
  genvar gi;
  generate
    for (gi = 0; gi < rvp_pkg::TM_COUNT; gi++)
    begin : g_tm
      rvp_timer #(.W(32)) u_tm (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_run(tm_run[gi]),
        .i_limit(tm_lim[gi]),
        .o_done(tm_done[gi])
      );
    end
  endgenerate

  // Limits; debounce length chosen per use by its select bit
  always_comb
  begin
    tm_lim[rvp_pkg::TM_REV_DEB] = ctl2_q[rvp_pkg::C2_REV_DEB_SEL] ?
      P_REV_DEB_SHORT : P_REV_DEB_LONG;
    tm_lim[rvp_pkg::TM_REV_UV] = P_REV_UV;
    tm_lim[rvp_pkg::TM_REV_OV] = P_RECOVER;
    tm_lim[rvp_pkg::TM_ADP_SET] = P_ADP_OV;
    tm_lim[rvp_pkg::TM_ADP_CLR] = P_RECOVER;
    tm_lim[rvp_pkg::TM_BOV_SET] = P_BAT_OV;
    tm_lim[rvp_pkg::TM_BOV_CLR] = P_BAT_OV;
    tm_lim[rvp_pkg::TM_OT_CLR] = P_RECOVER;
    tm_lim[rvp_pkg::TM_WOC_WIN] = P_WOC_WIN;
    tm_lim[rvp_pkg::TM_WOC_ACC] = P_WOC_ACC;
    tm_lim[rvp_pkg::TM_WOC_DEB] = ctl2_q[rvp_pkg::C2_WOC_DEB_SEL] ?
      P_REV_DEB_SHORT : P_REV_DEB_LONG;
  end

  // Run conditions: each timer measures one held condition
  always_comb
  begin
    tm_run[rvp_pkg::TM_REV_DEB] = (st_q == rvp_pkg::RV_DEBOUNCE);
    tm_run[rvp_pkg::TM_REV_UV] = (st_q == rvp_pkg::RV_RUN) && sn.rev_uv;
    tm_run[rvp_pkg::TM_REV_OV] = (st_q == rvp_pkg::RV_OV_HOLD) && !sn.rev_ov;
    tm_run[rvp_pkg::TM_ADP_SET] = !adp_flt_q && sn.adp_ov;
    tm_run[rvp_pkg::TM_ADP_CLR] = adp_flt_q && sn.adp_below_low;
    tm_run[rvp_pkg::TM_BOV_SET] = !bov_flt_q && sn.bat_ov;
    tm_run[rvp_pkg::TM_BOV_CLR] = bov_flt_q && sn.bat_below_half;
    tm_run[rvp_pkg::TM_OT_CLR] = ot_flt_q && sn.ot_below_low;
    tm_run[rvp_pkg::TM_WOC_WIN] = !woc_tick_q;
    tm_run[rvp_pkg::TM_WOC_ACC] = (woc_cnt_q != 3'h0) && !woc_flt_q;
    tm_run[rvp_pkg::TM_WOC_DEB] = woc_flt_q;
  end

  // Window end is registered so that done never feeds run directly
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      woc_tick_q <= 1'b0;
    end
    else
    begin
      woc_tick_q <= tm_done[rvp_pkg::TM_WOC_WIN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protection faults
  // Adapter overvoltage: qualify on entry and on recovery
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      adp_flt_q <= 1'b0;
    end
    else if (tm_done[rvp_pkg::TM_ADP_SET])
    begin
      adp_flt_q <= 1'b1;
    end
    else if (tm_done[rvp_pkg::TM_ADP_CLR])
    begin
      adp_flt_q <= 1'b0;
    end
  end

  // Battery overvoltage; cell-count margin lives in the analog threshold
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || ctl2_q[rvp_pkg::C2_BOV_DISABLE])
    begin
      bov_flt_q <= 1'b0;
    end
    else if (tm_done[rvp_pkg::TM_BOV_SET])
    begin
      bov_flt_q <= 1'b1;
    end
    else if (tm_done[rvp_pkg::TM_BOV_CLR])
    begin
      bov_flt_q <= 1'b0;
    end
  end

  // System overvoltage: no debounce either way, hysteresis is analog
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      sys_flt_q <= 1'b0;
    end
    else if (sn.sys_ov)
    begin
      sys_flt_q <= 1'b1;
    end
    else if (sn.sys_below_hyst)
    begin
      sys_flt_q <= 1'b0;
    end
  end

  // Over-temperature: immediate trip, delayed restart
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      ot_flt_q <= 1'b0;
    end
    else if (sn.ot_high)
    begin
      ot_flt_q <= 1'b1;
    end
    else if (tm_done[rvp_pkg::TM_OT_CLR])
    begin
      ot_flt_q <= 1'b0;
    end
  end

  // Gross overcurrent: one count per sample window, seven trip at once
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || ctl2_q[rvp_pkg::C2_WOC_DISABLE])
    begin
      woc_cnt_q <= 3'h0;
      woc_seen_q <= 1'b0;
      woc_flt_q <= 1'b0;
    end
    else if (woc_flt_q)
    begin
      // Count is cleared and held at zero during the retry debounce
      woc_cnt_q <= 3'h0;
      woc_seen_q <= 1'b0;
      woc_flt_q <= !tm_done[rvp_pkg::TM_WOC_DEB];
    end
    else if (sn.woc_trip && !woc_seen_q)
    begin
      woc_seen_q <= 1'b1;
      if (woc_cnt_q == rvp_pkg::WOC_TRIP_COUNT - 3'h1)
      begin
        woc_flt_q <= 1'b1;
      end
      else
      begin
        woc_cnt_q <= woc_cnt_q + 3'h1;
      end
    end
    else
    begin
      if (tm_done[rvp_pkg::TM_WOC_WIN])
      begin
        woc_seen_q <= 1'b0;
      end
      if (tm_done[rvp_pkg::TM_WOC_ACC])
      begin
        woc_cnt_q <= 3'h0; // Window lapsed below seven
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reverse output sequencer
  // Comparator owns the shared pins whenever its disable bit is clear
  assign cmp_en = !ctl2_q[rvp_pkg::C2_CMP_DISABLE];
  assign rev_en = ctl1_q[rvp_pkg::C1_REV_ENABLE];
  // With the comparator on, the enable pin is not consulted
  assign rev_qual = rev_en && sn.vbat_above_min && !sn.battery_absent_pin
    && !sn.single_cell && !woc_flt_q
    && (cmp_en || sn.reverse_enable_pin);

  // Next state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      rvp_pkg::RV_OFF:
        if (rev_qual)
        begin
          st_d = rvp_pkg::RV_DEBOUNCE;
        end
      rvp_pkg::RV_DEBOUNCE:
        if (!rev_qual)
        begin
          st_d = rvp_pkg::RV_OFF;
        end
        else if (tm_done[rvp_pkg::TM_REV_DEB] && sn.input_sense_below_ov)
        begin
          st_d = rvp_pkg::RV_RUN;
        end
      rvp_pkg::RV_RUN:
        if (!rev_qual)
        begin
          st_d = rvp_pkg::RV_OFF;
        end
        else if (sn.rev_ov)
        begin
          st_d = rvp_pkg::RV_OV_HOLD;
        end
        else if (tm_done[rvp_pkg::TM_REV_UV])
        begin
          st_d = rvp_pkg::RV_DEBOUNCE;
        end
      rvp_pkg::RV_OV_HOLD:
        if (!rev_qual)
        begin
          st_d = rvp_pkg::RV_OFF;
        end
        else if (tm_done[rvp_pkg::TM_REV_OV])
        begin
          st_d = rvp_pkg::RV_RUN;
        end
      default: st_d = rvp_pkg::RV_OFF;
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      st_q <= rvp_pkg::RV_OFF;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  logic any_flt;
  logic rev_busy; // Reverse requested but not yet (or no longer) running
  assign any_flt = adp_flt_q || bov_flt_q || sys_flt_q || ot_flt_q
    || woc_flt_q;
  assign rev_busy = (st_q == rvp_pkg::RV_DEBOUNCE)
    || (st_q == rvp_pkg::RV_OV_HOLD);

  // Power stage controls
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_switch_en <= 1'b0;
      o_adapter_switch_gate <= 1'b0;
      o_battery_switch_gate <= 1'b0;
      o_adapter_present_flag <= 1'b0;
    end
    else
    begin
      o_switch_en <= !any_flt && !rev_busy;
      // Debounce entry after undervoltage keeps the gate off
      o_adapter_switch_gate <= !adp_flt_q && !woc_flt_q && !rev_busy
        && !ctl2_q[rvp_pkg::C2_ASG_FORCE_OFF];
      o_battery_switch_gate <= adp_flt_q
        || (st_q != rvp_pkg::RV_OFF);
      o_adapter_present_flag <= sn.adp_valid && !adp_flt_q
        && !woc_flt_q;
    end
  end

  // Shared output pin: comparator, output good, or low
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_shared_out_pin <= 1'b0;
      o_cmp_ref_high <= 1'b0;
      o_rev_voltage_target <= rvp_pkg::RST_REV_OUT_VOLTAGE;
      o_rev_current_limit <= rvp_pkg::RST_REV_OUT_CUR_LIMIT;
    end
    else
    begin
      if (cmp_en)
      begin
        o_shared_out_pin <= ref_on
          && (sn.cmp_above_ref ^ ctl2_q[rvp_pkg::C2_CMP_INVERT]);
      end
      else
      begin
        o_shared_out_pin <= rev_en && (st_q == rvp_pkg::RV_RUN)
          && sn.rev_at_target && !sn.rev_uv;
      end
      o_cmp_ref_high <= ctl2_q[rvp_pkg::C2_CMP_REF_SEL];
      o_rev_voltage_target <= vout_q;
      o_rev_current_limit <= ilim_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence adp_isolated_s;
    !o_adapter_switch_gate && o_battery_switch_gate && !o_adapter_present_flag;
  endsequence
  sequence stop_switch_s;
    ##2 !o_switch_en;
  endsequence

  adp_ov_isolate_a: assert property (adp_flt_q
    |-> ##1 adp_isolated_s)
    else $error("adapter overvoltage did not isolate adapter");
  fault_stop_a: assert property (any_flt |-> ##1 !o_switch_en)
    else $error("switching enabled during a fault");
  sys_ov_stop_a: assert property (sn.sys_ov |-> stop_switch_s)
    else $error("system overvoltage did not stop switching");
  force_gate_a: assert property (
    $rose(ctl2_q[rvp_pkg::C2_ASG_FORCE_OFF]) |-> ##1 !o_adapter_switch_gate)
    else $error("adapter gate not forced off");
  input_sense_wait_a: assert property (
    (st_q == rvp_pkg::RV_DEBOUNCE) && !sn.input_sense_below_ov
    |=> st_q != rvp_pkg::RV_RUN)
    else $error("reverse started above input overvoltage");
  absent_block_a: assert property (
    sn.battery_absent_pin |=> st_q == rvp_pkg::RV_OFF)
    else $error("reverse mode with battery absent");
  woc_seven_a: assert property ($rose(woc_flt_q)
    |-> $past(woc_cnt_q) == 3'h6 && $past(sn.woc_trip))
    else $error("overcurrent trip at wrong count");
  woc_disable_a: assert property (
    ctl2_q[rvp_pkg::C2_WOC_DISABLE] |=> !woc_flt_q && woc_cnt_q == 3'h0)
    else $error("overcurrent guard active while disabled");
  rev_ov_hold_a: assert property (
    (st_q == rvp_pkg::RV_RUN) && rev_qual && sn.rev_ov
    |=> st_q == rvp_pkg::RV_OV_HOLD ##1 !o_switch_en)
    else $error("reverse overvoltage did not stop switching");
  cmp_polarity_a: assert property (
    cmp_en && ref_on && sn.cmp_above_ref
    && !ctl2_q[rvp_pkg::C2_CMP_INVERT] |=> o_shared_out_pin)
    else $error("comparator output polarity wrong");
  // Pin owner is judged in the cycle that computed the new level
  good_needs_run_a: assert property (
    $rose(o_shared_out_pin) && $past(!cmp_en)
    |-> $past(st_q) == rvp_pkg::RV_RUN)
    else $error("output good outside running state");

endmodule
`default_nettype wire

// File: test/rvp_analog_model.sv
// Analog stage model: reverse output ramps up while switching runs
`timescale 1ns/10ps
`default_nettype none
module rvp_analog_model #(
  parameter int P_RAMP = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_switch_en,
  output logic o_at_target
);
  // Ramp count; output collapses at once when switching stops
  int ramp_q = 0;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_switch_en)
      ramp_q <= 0;
    else if (ramp_q < P_RAMP)
      ramp_q <= ramp_q + 1;
  end
  // Target is reached only after a full ramp
  assign o_at_target = (ramp_q == P_RAMP);
endmodule
`default_nettype wire

// File: test/rvp_ctrl_tb_top.sv
// Testbench: register access and supervision scenarios for the controller
`timescale 1ns/10ps
`default_nettype none
module rvp_ctrl_tb_top;
  logic clk = 1'b0; // Reference clock
  logic rst = 1'b1; // Synchronous reset
  rvp_pkg::rvp_reg_req_t req = '0; // Register strobes
  rvp_pkg::rvp_sense_t sv = '0; // Levels set by the bench
  rvp_pkg::rvp_sense_t sn; // Levels seen by the block
  logic at_tgt;
  logic [15:0] rdata, vtgt, ilim, d;
  logic sw_en, agate, battery_switch_gate, apres, shout, refh;
  int failures = 0;
  int check_count = 0;
  int n;
  localparam int TB_DEB_LONG = 200; // Shortened long debounce
  ////////////////////////////////////////////////////////////////////
  // Clock at 8 ns period
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Output level comes from the analog model
  always_comb
  begin
    sn = sv;
    sn.rev_at_target = at_tgt;
  end
  // Shortened debounces; adapter and overcurrent windows keep defaults
  rvp_ctrl #(.P_REV_DEB_LONG(TB_DEB_LONG), .P_REV_DEB_SHORT(50),
    .P_REV_UV(40), .P_RECOVER(10), .P_BAT_OV(20))
    rvp_ctrl_i (.i_ref_clk(clk), .i_reset(rst),
    .i_reg(req), .i_sense(sn), .o_reg_rdata(rdata), .o_switch_en(sw_en),
    .o_adapter_switch_gate(agate), .o_battery_switch_gate(battery_switch_gate),
    .o_adapter_present_flag(apres), .o_shared_out_pin(shout),
    .o_cmp_ref_high(refh), .o_rev_voltage_target(vtgt),
    .o_rev_current_limit(ilim));
  rvp_analog_model rvp_analog_model_i (.i_ref_clk(clk),
    .i_switch_en(sw_en), .o_at_target(at_tgt));
  ////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Step whole cycles, landing just after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    cyc(1);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    cyc(1);
    req.wr = 1'b0;
  endtask
  // One-cycle read strobe; data held after the next edge
  task automatic rd(input logic [7:0] a);
    cyc(1);
    req.rd = 1'b1;
    req.addr = a;
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
    d = rdata;
  endtask
  // Bounded wait on switching enable or the shared output
  task automatic wait_lvl(input bit pick, input logic v, input int lim);
    n = 0;
    while (((pick ? shout : sw_en) !== v) && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  // Counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog, far beyond the expected run length
  initial
  begin
    #400000;
    failures++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(12);
    rst = 1'b0;
    chk("ilim port", ilim, 16'h0200);
    rd(8'h4a);
    chk("ilim reg", d, 16'h0200);
    wr(8'h4a, 16'h0100);
    rd(8'h4a);
    chk("ilim new", d, 16'h0100);
    wr(8'h49, 16'hffff);
    rd(8'h49);
    chk("vtgt reg", d, 16'h7ff8);
    chk("vtgt port", vtgt, 16'h7ff8);
    rd(8'h50);
    chk("unmapped", d, 16'h0000);
    // Qualified reverse request, pin mode, short debounce
    sv.adp_valid = 1'b1;
    sv.vbat_above_min = 1'b1;
    sv.reverse_enable_pin = 1'b1;
    sv.input_sense_below_ov = 1'b1;
    wr(8'h3d, 16'h2008);
    wr(8'h3c, 16'h0800);
    cyc(30);
    chk("sw_en deb", sw_en, 1'b0);
    chk("good deb", shout, 1'b0);
    wait_lvl(0, 1'b1, 60);
    chk("sw_en run", sw_en, 1'b1);
    chk("deb long", n > 15, 1'b1);
    wait_lvl(1, 1'b1, 30);
    chk("good", shout, 1'b1);
    chk("agate on", agate, 1'b1);
    wr(8'h3d, 16'h2028);
    cyc(2);
    chk("agate off", agate, 1'b0);
    wr(8'h3d, 16'h2008);
    // System rail fault, then recovery with no debounce
    sv.sys_ov = 1'b1;
    cyc(5);
    chk("sys ov", sw_en, 1'b0);
    sv.sys_ov = 1'b0;
    sv.sys_below_hyst = 1'b1;
    wait_lvl(0, 1'b1, 12);
    chk("sys back", sw_en, 1'b1);
    // Output overvoltage holds switching off, short recovery
    sv.rev_ov = 1'b1;
    cyc(5);
    chk("rev ov", sw_en, 1'b0);
    sv.rev_ov = 1'b0;
    wait_lvl(0, 1'b1, 20);
    chk("rev ov back", sw_en, 1'b1);
    // Comparator enabled while running: pin no longer needed
    wr(8'h3d, 16'h2000);
    sv.reverse_enable_pin = 1'b0;
    cyc(4);
    chk("no pin", sw_en, 1'b1);
    rd(8'h3a);
    chk("mode", d[6:5], 2'h3);
    chk("ref on", d[15], 1'b1);
    sv.cmp_above_ref = 1'b1;
    cyc(5);
    chk("cmp out", shout, 1'b1);
    wr(8'h3d, 16'h2004);
    cyc(3);
    chk("cmp inv", shout, 1'b0);
    wr(8'h3d, 16'h2014);
    cyc(2);
    chk("ref sel", refh, 1'b1);
    sv.battery_absent_pin = 1'b1;
    cyc(5);
    chk("absent", battery_switch_gate, 1'b0);
    rd(8'h3a);
    chk("absent mode", d[6:5], 2'h0);
    // Adapter overvoltage: qualified, isolates, then recovers
    sv.adp_ov = 1'b1;
    cyc(rvp_pkg::CY_ADP_OV - 4);
    chk("adp early", apres, 1'b1);
    cyc(12);
    chk("adp apres", apres, 1'b0);
    chk("adp agate", agate, 1'b0);
    chk("adp battery_switch_gate", battery_switch_gate, 1'b1);
    chk("adp sw", sw_en, 1'b0);
    sv.adp_ov = 1'b0;
    sv.adp_below_low = 1'b1;
    cyc(20);
    chk("adp back", apres, 1'b1);
    chk("adp gate on", agate, 1'b1);
    // Gross overcurrent: seven windows trip, long retry, then disable
    sv.woc_trip = 1'b1;
    wait_lvl(0, 1'b0, 9000);
    chk("woc trip", sw_en, 1'b0);
    chk("woc apres", apres, 1'b0);
    chk("woc win", n > 5 * rvp_pkg::CY_WOC_WIN, 1'b1);
    wait_lvl(0, 1'b1, 300);
    chk("woc retry", 16'(n), 16'(TB_DEB_LONG + 1));
    wr(8'h3d, 16'h2016);
    cyc(7 * (rvp_pkg::CY_WOC_WIN + 2) + 20);
    chk("woc off", sw_en, 1'b1);
    sv.woc_trip = 1'b0;
    // Both functions off leaves the shared output low
    wr(8'h3c, 16'h0000);
    wr(8'h3d, 16'h0008);
    cyc(3);
    chk("pins off", shout, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
